// ===== core/fcm_flash_host.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fcm_consts.svh"
// How it works
// - status read is a command write then a read; oe falls last.
// - host never issues the reserved code 00h.
// - reads hold chip select and output enable low, write enable and reset high, data drive off.
// - identification command goes to the bank holding address zero.
// - after identification, read-array to bank zero precedes any command.
// - query command goes to bank zero; read-array to bank zero leaves query mode.
module fcm_flash_host
    import fcm_pkg::*;
#(
    parameter int            ADDR_W     = 22,
    parameter logic [31:0]   BANK0_LAST = 32'h000fffff
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic                   flash_reset_powerdown_n,
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [15:0]       flash_dq_in,
    output logic [15:0]            flash_dq_out,
    output logic                   flash_dq_oe
);

    generate
        if (ADDR_W < 8 || ADDR_W > 31) begin : g_bad_width
            $error("fcm_flash_host: ADDR_W must lie in 8..31");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fcm_state_t          st;
        logic [7:0]          cnt;
        logic                second;
        fcm_op_t             op;
        logic [ADDR_W-1:0]   areg;
        logic [15:0]         d1;
        logic [15:0]         d2;
        logic [15:0]         rd;
        logic                busy;
        logic                refused;
        logic                id_lock;
        logic                query;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                rp_n;
        logic                dq_oe;
        logic [15:0]         dq_out;
        logic [ADDR_W-1:0]   a;
        logic [15:0]         s1;
        logic [15:0]         s2;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } fcm_regs_t;

    fcm_regs_t r;
    fcm_regs_t next_r;

    function automatic logic [2:0] fcm_sel(input logic [7:0] adr);
        case (adr)
            `FCM_OFS_CTRL:   fcm_sel = 3'h1;
            `FCM_OFS_ADDR:   fcm_sel = 3'h2;
            `FCM_OFS_DATA1:  fcm_sel = 3'h3;
            `FCM_OFS_DATA2:  fcm_sel = 3'h4;
            `FCM_OFS_STATUS: fcm_sel = 3'h5;
            `FCM_OFS_RDATA:  fcm_sel = 3'h6;
            default:         fcm_sel = 3'h0;
        endcase
    endfunction

    function automatic logic in_bank0(input logic [ADDR_W-1:0] adr);
        in_bank0 = 32'(adr) <= BANK0_LAST;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic       access;
        logic [2:0] sel;
        logic       start;
        logic       rst_req;
        logic       bad;
        logic [7:0] code;
        fcm_op_t    op_new;
        logic       done;
        access  = psel && penable && !r.pready;
        sel     = fcm_sel(paddr);
        start   = 1'b0;
        rst_req = 1'b0;
        bad     = 1'b0;
        done    = 1'b0;
        code    = r.d1[7:0];
        op_new  = fcm_op_t'(pwdata[`FCM_CTRL_OP_LO +: 2]);
        next_r  = r;
        next_r.s1      = flash_dq_in;
        next_r.s2      = r.s1;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;

        // apb slave: answers one cycle into the access phase
        if (access) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            if (sel == 3'h0) begin
                next_r.pslverr = 1'b1;
            end else if (pwrite) begin
                // operands are frozen while a cycle runs on the pins
                case (sel)
                    3'h1: begin
                        start   = pwdata[`FCM_CTRL_START];
                        rst_req = pwdata[`FCM_CTRL_RESET];
                    end
                    3'h2: if (!r.busy) next_r.areg = pwdata[ADDR_W-1:0];
                    3'h3: if (!r.busy) next_r.d1 = pwdata[15:0];
                    3'h4: if (!r.busy) next_r.d2 = pwdata[15:0];
                    3'h5: if (pwdata[`FCM_ST_REFUSED])
                        next_r.refused = 1'b0;
                    default: ;
                endcase
            end else begin
                case (sel)
                    3'h2: next_r.prdata = 32'(r.areg);
                    3'h3: next_r.prdata = {16'h0, r.d1};
                    3'h4: next_r.prdata = {16'h0, r.d2};
                    3'h5: next_r.prdata = {27'h0, !r.rp_n, r.query,
                                           r.id_lock, r.refused, r.busy};
                    3'h6: next_r.prdata = {16'h0, r.rd};
                    default: next_r.prdata = 32'h0;
                endcase
            end
        end

        // command screening before anything reaches the pins
        if (start) begin
            if (op_new != OP_RD) begin
                if (code == `FCM_CMD_RESERVED)
                    bad = 1'b1;
                if ((code == `FCM_CMD_READ_ID || code == `FCM_CMD_QUERY)
                    && !in_bank0(r.areg))
                    bad = 1'b1;
                if (r.id_lock && !(code == `FCM_CMD_READ_ARR
                    && in_bank0(r.areg)))
                    bad = 1'b1;
            end
            if (r.st != S_IDLE || rst_req)
                bad = 1'b1;
        end
        // refusal set wins over a clear in the same cycle
        if (start && bad)
            next_r.refused = 1'b1;

        case (r.st)
            S_RST: begin
                if (r.cnt <= 8'h01) begin
                    next_r.rp_n  = 1'b1;
                    // device is back in read-array mode here
                    next_r.id_lock = 1'b0;
                    next_r.query   = 1'b0;
                    next_r.st    = S_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            S_IDLE: begin
                if (rst_req) begin
                    next_r.rp_n = 1'b0;
                    next_r.cnt  = 8'(`FCM_RP_CYC);
                    next_r.st   = S_RST;
                end else if (start && !bad) begin
                    next_r.busy   = 1'b1;
                    next_r.second = 1'b0;
                    next_r.op     = op_new;
                    next_r.a      = r.areg;
                    next_r.ce_n   = 1'b0;
                    next_r.st     = S_SETUP;
                end
            end
            S_SETUP: begin
                if (r.op == OP_RD || (r.op == OP_WRRD && r.second)) begin
                    next_r.oe_n = 1'b0;
                    next_r.cnt  = 8'(`FCM_RD_CYC);
                    next_r.st   = S_RLOW;
                end else begin
                    next_r.we_n   = 1'b0;
                    next_r.dq_oe  = 1'b1;
                    next_r.dq_out = r.second ? r.d2 : r.d1;
                    next_r.cnt    = 8'(`FCM_WP_CYC);
                    next_r.st     = S_WLOW;
                end
            end
            S_WLOW: begin
                if (r.cnt <= 8'h01) begin
                    next_r.we_n = 1'b1;
                    next_r.st   = S_WHOLD;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            S_WHOLD: begin
                // data held one cycle past the rising write strobe
                next_r.dq_oe = 1'b0;
                next_r.ce_n  = 1'b1;
                if (r.op != OP_WR1 && !r.second) begin
                    next_r.second = 1'b1;
                    next_r.st     = S_GAP;
                end else begin
                    next_r.busy = 1'b0;
                    next_r.st   = S_IDLE;
                    done        = 1'b1;
                end
            end
            S_GAP: begin
                // chip select dropped first so output or write enable falls last
                next_r.ce_n = 1'b0;
                next_r.st   = S_SETUP;
            end
            S_RLOW: begin
                if (r.cnt <= 8'h01) begin
                    next_r.rd   = r.s2;
                    next_r.oe_n = 1'b1;
                    next_r.ce_n = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.st   = S_IDLE;
                    done        = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase

        // a write-then-read also leaves the partition in id or query mode
        if (done && r.op != OP_RD) begin
            if (code == `FCM_CMD_READ_ID)
                next_r.id_lock = 1'b1;
            if (code == `FCM_CMD_QUERY)
                next_r.query = 1'b1;
            if (code == `FCM_CMD_READ_ARR && in_bank0(r.a)) begin
                next_r.id_lock = 1'b0;
                next_r.query   = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            r      <= '0;
            r.ce_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.we_n <= 1'b1;
            r.cnt  <= 8'(`FCM_RP_CYC);
        end else begin
            r <= next_r;
        end
    end

    assign prdata                  = r.prdata;
    assign pready                  = r.pready;
    assign pslverr                 = r.pslverr;
    assign flash_ce_n              = r.ce_n;
    assign flash_oe_n              = r.oe_n;
    assign flash_we_n              = r.we_n;
    assign flash_reset_powerdown_n = r.rp_n;
    assign flash_addr              = r.a;
    assign flash_dq_out            = r.dq_out;
    assign flash_dq_oe             = r.dq_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_NO_RESERVED: assert property (
        (!flash_we_n && !r.second) |-> flash_dq_out[7:0] != 8'h00)
        else $error("reserved code driven");
    AST_READ_PINS: assert property (
        !flash_oe_n |-> (!flash_ce_n && flash_we_n
                         && flash_reset_powerdown_n && !flash_dq_oe))
        else $error("bad pin levels during read");
    AST_WRITE_PINS: assert property (
        !flash_we_n |-> (!flash_ce_n && flash_oe_n && flash_dq_oe))
        else $error("bad pin levels during write");
    AST_WE_WIDTH: assert property (
        $fell(flash_we_n) |-> !flash_we_n[*3] ##1 flash_we_n)
        else $error("write strobe width wrong");
    AST_STATUS_SEQ: assert property (
        ($rose(flash_we_n) && r.op == OP_WRRD && !r.second)
        |-> flash_oe_n[*3] ##1 ($fell(flash_oe_n) && !flash_ce_n
            && !$past(flash_ce_n)))
        else $error("read does not follow command write");
    AST_READ_LEN: assert property (
        $fell(flash_oe_n) |-> !flash_oe_n[*6] ##1 (flash_oe_n && !r.busy))
        else $error("read cycle length wrong");
    AST_ID_BANK: assert property (
        (!flash_we_n && !r.second
         && (flash_dq_out[7:0] == 8'h90 || flash_dq_out[7:0] == 8'h98))
        |-> 32'(flash_addr) <= BANK0_LAST)
        else $error("id or query command outside bank zero");
    AST_ID_EXIT: assert property (
        (!flash_we_n && !r.second && r.id_lock)
        |-> flash_dq_out[7:0] == 8'hff && 32'(flash_addr) <= BANK0_LAST)
        else $error("command issued before leaving id mode");
    AST_APB_ANSWER: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    AST_RESET_PULSE: assert property (
        $rose(nrst) |-> !flash_reset_powerdown_n[*5]
                        ##1 flash_reset_powerdown_n)
        else $error("reset pulse length wrong");

    COV_STATUS_READ: cover property (
        $rose(flash_we_n) && r.op == OP_WRRD && !r.second ##[1:20]
        $rose(flash_oe_n));
    COV_REFUSED: cover property ($rose(r.refused));
    COV_ID_CYCLE: cover property ($rose(r.id_lock) ##[1:200] $fell(r.id_lock));

endmodule

// ===== inc/fcm_consts.svh
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define FCM_OFS_CTRL    8'h00
`define FCM_OFS_ADDR    8'h04
`define FCM_OFS_DATA1   8'h08
`define FCM_OFS_DATA2   8'h0c
`define FCM_OFS_STATUS  8'h10
`define FCM_OFS_RDATA   8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCM_CTRL_START  0
`define FCM_CTRL_OP_LO  1
`define FCM_CTRL_RESET  4
`define FCM_ST_BUSY     0
`define FCM_ST_REFUSED  1
`define FCM_ST_IDLOCK   2
`define FCM_ST_QUERY    3
`define FCM_ST_RESET    4

// ----------------------------------------------------------------
// flash command codes
// ----------------------------------------------------------------
`define FCM_CMD_RESERVED 8'h00
`define FCM_CMD_READ_ARR 8'hff
`define FCM_CMD_READ_ID  8'h90
`define FCM_CMD_QUERY    8'h98

// ----------------------------------------------------------------
// timing: ns as printed, cycles derived (least times round up)
// ----------------------------------------------------------------
`define FCM_CLK_NS      20
`define FCM_T_WP_NS     60
`define FCM_T_ACC_NS    80
`define FCM_T_RP_NS     100
`define FCM_WP_CYC  ((`FCM_T_WP_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_ACC_CYC ((`FCM_T_ACC_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_RP_CYC  ((`FCM_T_RP_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_SYNC_CYC 2
`define FCM_RD_CYC  (`FCM_ACC_CYC + `FCM_SYNC_CYC)

`endif

// ===== inc/fcm_pkg.sv
package fcm_pkg;
    typedef enum logic [2:0] {
        S_RST, S_IDLE, S_SETUP, S_WLOW, S_WHOLD, S_GAP, S_RLOW
    } fcm_state_t;

    typedef enum logic [1:0] {
        OP_WR1, OP_WR2, OP_WRRD, OP_RD
    } fcm_op_t;
endpackage

// ===== test/fcm_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-partition flash device seen from its pins
// ----------------------------------------------------------------
module fcm_flash_model #(
    parameter logic [31:0] BANK0_LAST = 32'h000fffff,
    parameter logic [15:0] ID_CODE    = 16'h5a3c, // arbitrary value
    parameter logic [15:0] CFI_WORD   = 16'h0c3a, // arbitrary value
    parameter int          ERASE_NS   = 2000
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] dq_wr,
    output logic [15:0]      dq_rd
);
    logic [15:0] mem [4096];
    logic [1:0]  lk [1024];
    logic [1:0]  mode [2];
    logic [7:0]  pend [2];
    logic [7:0]  st [2];
    logic [15:0] last;
    logic        busy, bp, p, pr, susp;
    logic [7:0]  c;
    logic [9:0]  b;

    initial begin
        foreach (mem[i]) mem[i] = 16'(i) ^ 16'ha5a5;
        foreach (lk[i]) lk[i] = 2'b00;
        mode = '{2'd0, 2'd0};
        pend = '{8'h00, 8'h00};
        st = '{8'h00, 8'h00};
        last = 16'h0000;
        dq_rd = 16'hffff;
        busy = 1'b0;
        bp = 1'b0;
        susp = 1'b0;
    end

    // mode 0 array, 1 id, 2 query, 3 status
    always @(ce_n or oe_n) begin
        if (!ce_n && !oe_n && rp_n) begin
            pr = (32'(addr) > BANK0_LAST);
            case (mode[pr])
                2'd0: last = mem[addr[11:0]];
                2'd1: last = (addr[3:0] == 4'h2) ? {14'h0, lk[addr[21:12]]}
                                                 : ID_CODE;
                2'd2: last = CFI_WORD;
                default: last = {8'h00, !(busy && !susp && bp == pr),
                                 st[pr][6:0]};
            endcase
            dq_rd = last;
        end else begin
            // no pull on the bus: released lines must not look valid
            dq_rd = ~last;
        end
    end

    always @(posedge busy) begin
        #(ERASE_NS);
        busy = 1'b0;
    end

    always @(posedge we_n or negedge rp_n) begin
        if (!rp_n) begin
            mode = '{2'd0, 2'd0};
            pend = '{8'h00, 8'h00};
            st = '{8'h00, 8'h00};
            busy = 1'b0;
            susp = 1'b0;
        end else if (!ce_n) begin
            p = (32'(addr) > BANK0_LAST);
            c = dq_wr[7:0];
            b = addr[21:12];
            if (busy && bp == p) begin
                if (c == 8'h70) mode[p] = 2'd3;
                if (c == 8'hb0) begin
                    susp = 1'b1;
                    st[p][6] = 1'b1;
                end
                if (c == 8'hd0 && susp) begin
                    susp = 1'b0;
                    st[p][6] = 1'b0;
                end
            end else if (pend[p] == 8'h20) begin
                pend[p] = 8'h00;
                mode[p] = 2'd3;
                if (c == 8'hd0) begin
                    foreach (mem[i]) mem[i] = 16'hffff;
                    busy = 1'b1;
                    bp = p;
                end else if (c == 8'hd1) begin
                    foreach (mem[i])
                        if (mem[i] !== 16'hffff) st[p][5] = 1'b1;
                end
            end else if (pend[p] == 8'h60) begin
                pend[p] = 8'h00;
                mode[p] = 2'd3;
                case (c)
                    8'h01: lk[b][0] = 1'b1;
                    8'h2f: lk[b] = 2'b11;
                    8'hd0: if (!lk[b][1]) lk[b][0] = 1'b0;
                    default: ;
                endcase
            end else if (pend[p] != 8'h00) begin
                pend[p] = 8'h00;
                if (lk[b][0]) st[p] = st[p] | 8'h12;
                else mem[addr[11:0]] = dq_wr;
            end else begin
                case (c)
                    8'hff: mode[p] = 2'd0;
                    8'h90: mode[p] = 2'd1;
                    8'h98: mode[p] = 2'd2;
                    8'h70: mode[p] = 2'd3;
                    8'h50: begin
                        st[p] = 8'h00;
                        mode[p] = 2'd0;
                    end
                    8'h10, 8'h20, 8'h40, 8'h60: begin
                        pend[p] = c;
                        mode[p] = 2'd3;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "fcm_consts.svh"
module testbench;
    import fcm_pkg::*;
    localparam logic [31:0] B0_LAST = 32'h000fffff;
    localparam logic [15:0] CFI     = 16'h0c3a;
    logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        ce_n, oe_n, we_n, rp_n, dq_oe;
    logic [21:0] fa;
    logic [15:0] dq_in, dq_out;
    int          error_cnt, n_tests, cyc;

    fcm_flash_host #(.ADDR_W(22), .BANK0_LAST(B0_LAST)) dut (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_reset_powerdown_n(rp_n), .flash_addr(fa),
        .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));

    fcm_flash_model #(.BANK0_LAST(B0_LAST), .CFI_WORD(CFI),
                      .ERASE_NS(4000)) flash (
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .addr(fa),
        .dq_wr(dq_out), .dq_rd(dq_in));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic fop(input fcm_op_t op, input logic [21:0] a,
                       input logic [15:0] d1, input logic [15:0] d2);
        int n;
        n = 0;
        apb(1'b1, `FCM_OFS_ADDR, {10'h0, a});
        apb(1'b1, `FCM_OFS_DATA1, {16'h0, d1});
        apb(1'b1, `FCM_OFS_DATA2, {16'h0, d2});
        apb(1'b1, `FCM_OFS_CTRL, {29'h0, op, 1'b1});
        do begin
            apb(1'b0, `FCM_OFS_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
    endtask

    task automatic rd(input fcm_op_t op, input logic [21:0] a,
                      input logic [15:0] d1, input logic [15:0] x);
        fop(op, a, d1, 16'h0);
        apb(1'b0, `FCM_OFS_RDATA, 32'h0);
        chk("rdata", {16'h0, x}, q);
    endtask

    // reads status, then clears the refused bit for the next case
    task automatic chk_st(input logic [31:0] x);
        apb(1'b0, `FCM_OFS_STATUS, 32'h0);
        chk("status", x, q);
        apb(1'b1, `FCM_OFS_STATUS, 32'h2);
    endtask

    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {error_cnt, n_tests, cyc} = '0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (10) @(posedge mclk);
        chk_st(32'h0);
        rd(OP_RD, 22'h5, 16'h0, 16'h0005 ^ 16'ha5a5);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        fop(OP_WR2, 22'h10, 16'h40, 16'h1234);
        rd(OP_WRRD, 22'h10, 16'hff, 16'h1234);
        rd(OP_WRRD, 22'h10, 16'h70, 16'h0080);
        fop(OP_WR2, 22'h10, 16'h20, 16'hd0);
        rd(OP_WRRD, 22'h10, 16'hff, 16'h0000);
        fop(OP_WR1, 22'h10, 16'hb0, 16'h0);
        rd(OP_RD, 22'h10, 16'h0, 16'h00c0);
        fop(OP_WR1, 22'h10, 16'hd0, 16'h0);
        rd(OP_RD, 22'h10, 16'h0, 16'h0000);
        repeat (220) @(posedge mclk);
        rd(OP_WRRD, 22'h10, 16'h70, 16'h0080);
        rd(OP_WRRD, 22'h10, 16'hff, 16'hffff);
        fop(OP_WR2, 22'h10, 16'h40, 16'h0000);
        fop(OP_WR2, 22'h10, 16'h20, 16'hd1);
        rd(OP_RD, 22'h10, 16'h0, 16'h00a0);
        fop(OP_WR1, 22'h10, 16'h50, 16'h0);
        rd(OP_RD, 22'h10, 16'h0, 16'h0000);
        rd(OP_WRRD, 22'h10, 16'h70, 16'h0080);
        fop(OP_WR2, 22'h1000, 16'h60, 16'h01);
        rd(OP_WRRD, 22'h1002, 16'h90, 16'h0001);
        fop(OP_WR1, 22'h1000, 16'h70, 16'h0);
        chk_st(32'h6);
        fop(OP_WR1, 22'h0, 16'hff, 16'h0);
        chk_st(32'h0);
        fop(OP_WR2, 22'h1005, 16'h40, 16'h7777);
        rd(OP_RD, 22'h1005, 16'h0, 16'h0092);
        fop(OP_WR1, 22'h1005, 16'h50, 16'h0);
        rd(OP_RD, 22'h1005, 16'h0, 16'hffff);
        fop(OP_WR2, 22'h2000, 16'h60, 16'h2f);
        fop(OP_WR2, 22'h2000, 16'h60, 16'hd0);
        rd(OP_WRRD, 22'h2002, 16'h90, 16'h0003);
        fop(OP_WR1, 22'h0, 16'hff, 16'h0);
        fop(OP_WR2, 22'h1000, 16'h60, 16'hd0);
        rd(OP_WRRD, 22'h1002, 16'h90, 16'h0000);
        fop(OP_WR1, 22'h0, 16'hff, 16'h0);
        fop(OP_WR2, 22'h10, 16'h60, 16'hff);
        rd(OP_RD, 22'h10, 16'h0, 16'h0080);
        rd(OP_WRRD, 22'h0, 16'h98, CFI);
        chk_st(32'h8);
        fop(OP_WR1, 22'h0, 16'hff, 16'h0);
        rd(OP_RD, 22'h10, 16'h0, 16'h0000);
        fop(OP_WR1, 22'h100000, 16'h98, 16'h0);
        chk_st(32'h2);
        fop(OP_WR1, 22'h10, 16'h00, 16'h0);
        chk_st(32'h2);
        fop(OP_WR1, 22'h100010, 16'h70, 16'h0);
        rd(OP_RD, 22'h10, 16'h0, 16'h0000);
        rd(OP_RD, 22'h100010, 16'h0, 16'h0080);
        apb(1'b1, `FCM_OFS_CTRL, 32'h10);
        repeat (20) @(posedge mclk);
        chk_st(32'h0);
        rd(OP_RD, 22'h100010, 16'h0, 16'h0000);
        give_verdict();
    end
endmodule
